// [verilog/fileop_core.v]
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "fileop_regs.vh"
// File register execution unit with an APB register port
module fileop_core (
  input  wire        CLK,
  input  wire        RST,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  output reg         SLEEP_MODE,
  output reg         BUSY
);

  localparam ST_IDLE  = 2'd0;
  localparam ST_EXEC  = 2'd1;
  localparam ST_FLUSH = 2'd2;

  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [2:0]  op_r;
  reg         target_sel_r;
  reg  [6:0]  operand_reg_r;
  reg  [7:0]  acc_r;
  reg         rotate_out_bit_r;
  reg         result_null_flag_r;
  reg         power_down_flag_r;
  reg         timeout_flag_r;
  reg         sleeping_r;
  reg         wdog_en_r;
  reg  [12:0] program_counter_r;
  reg  [7:0]  watchdog_counter_r;
  reg  [7:0]  prescaler_r;
  reg  [6:0]  findex_r;
  reg  [7:0]  file_r [0:127];
  integer     i;

  wire [7:0]  fval;
  wire [7:0]  alu_result;
  wire        alu_carry;
  wire        alu_zero;
  wire        upd_zero;
  wire        upd_carry;
  wire        has_result;
  wire [12:0] stack_top;
  wire [3:0]  stack_depth;

  // APB phases; zero wait state, answer registered at setup
  wire setup    = PSEL & ~PENABLE;
  wire wr_fire  = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;
  wire idle     = (state_r == ST_IDLE);
  wire exec     = (state_r == ST_EXEC);

  // One-hot write strobes at the access edge
  wire cmd_wr   = wr_fire & (PADDR == `CMD_ADDR);
  wire stat_wr  = wr_fire & (PADDR == `STATUS_ADDR);
  wire acc_wr   = wr_fire & (PADDR == `ACC_ADDR);
  wire pc_wr    = wr_fire & (PADDR == `PCNT_ADDR);
  wire stk_wr   = wr_fire & (PADDR == `STACK_ADDR);
  wire fidx_wr  = wr_fire & (PADDR == `FINDEX_ADDR);
  wire fdat_wr  = wr_fire & (PADDR == `FDATA_ADDR);
  wire wake_wr  = wr_fire & (PADDR == `WAKE_ADDR) & PWDATA[0];

  // Decoded instruction in flight
  wire do_sleep  = exec & (op_r == `OP_SLEEP);
  wire do_return = exec & (op_r == `OP_RETURN);
  wire wdog_wrap = wdog_en_r & (prescaler_r == 8'hFF) &
                   (watchdog_counter_r == 8'hFF);

  // Address is mapped at all
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `CMD_ADDR) | (a == `STATUS_ADDR) |
               (a == `ACC_ADDR) | (a == `PCNT_ADDR) |
               (a == `STACK_ADDR) | (a == `FINDEX_ADDR) |
               (a == `FDATA_ADDR) | (a == `WDOG_ADDR) |
               (a == `WAKE_ADDR);
    end
  endfunction

  // Writes that would race the datapath are refused while not idle
  function refused;
    input [7:0] a;
    input       wr;
    input       busy;
    input       asleep;
    begin
      if (!mapped(a)) begin
        refused = 1'b1;
      end else if (!wr || a == `WAKE_ADDR || a == `WDOG_ADDR) begin
        refused = 1'b0;
      end else if (a == `CMD_ADDR) begin
        refused = busy | asleep; // RULE_08
      end else begin
        refused = busy;
      end
    end
  endfunction

  // Status word as software sees it
  function [31:0] status_word;
    input b;
    input s;
    input c;
    input z;
    input pwdn;
    input tmo;
    input we;
    begin
      status_word = 32'h0000_0000;
      status_word[`ST_BUSY_BIT]  = b;
      status_word[`ST_SLEEP_BIT] = s;
      status_word[`ST_CARRY_BIT] = c;
      status_word[`ST_ZERO_BIT]  = z;
      status_word[`ST_PWDN_BIT]  = pwdn;
      status_word[`ST_TMO_BIT]   = tmo;
      status_word[`ST_WDEN_BIT]  = we;
    end
  endfunction

  // Read data mux
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (PADDR)
      `CMD_ADDR:    rd_mux = {21'h00_0000, operand_reg_r, target_sel_r,
                              op_r};
      `STATUS_ADDR: rd_mux = status_word(~idle, sleeping_r,
                              rotate_out_bit_r, result_null_flag_r,
                              power_down_flag_r, timeout_flag_r,
                              wdog_en_r);
      `ACC_ADDR:    rd_mux = {24'h00_0000, acc_r};
      `PCNT_ADDR:   rd_mux = {19'h0_0000, program_counter_r};
      `STACK_ADDR:  rd_mux = {12'h000, stack_depth, 3'h0, stack_top};
      `FINDEX_ADDR: rd_mux = {25'h000_0000, findex_r};
      `FDATA_ADDR:  rd_mux = {24'h00_0000, file_r[findex_r]};
      `WDOG_ADDR:   rd_mux = {16'h0000, prescaler_r,
                              watchdog_counter_r};
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  // Bus answer; error latched at setup so acceptance matches it
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else if (setup) begin
      PRDATA  <= PWRITE ? 32'h0000_0000 : rd_mux;
      PREADY  <= 1'b1;
      PSLVERR <= refused(PADDR, PWRITE, ~idle, sleeping_r);
    end else begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  // Operand fetch and combinational result
  assign fval = file_r[operand_reg_r];

  fileop_alu u_alu (
    .op         (op_r),
    .acc        (acc_r),
    .fval       (fval),
    .carry      (rotate_out_bit_r),
    .result     (alu_result),
    .carry_out  (alu_carry),
    .zero_out   (alu_zero),
    .upd_zero   (upd_zero),
    .upd_carry  (upd_carry),
    .has_result (has_result)
  );

  fileop_stack u_stack (
    .clk      (CLK),
    .rst      (RST),
    .push     (stk_wr),
    .pop      (do_return),
    .push_val (PWDATA[12:0]),
    .top      (stack_top),
    .depth    (stack_depth)
  );

  // Sequencer: one cycle per operation, return adds a flush cycle
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (cmd_wr) begin
          state_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (op_r == `OP_RETURN) begin
          state_nxt = ST_FLUSH; // RULE_10
        end else begin
          state_nxt = ST_IDLE;  // RULE_12
        end
      end
      ST_FLUSH: begin
        state_nxt = ST_IDLE;    // RULE_10
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_r       <= ST_IDLE;
      op_r          <= 3'h0;
      target_sel_r  <= 1'b0;
      operand_reg_r <= 7'h00;
      BUSY          <= 1'b0;
    end else begin
      state_r <= state_nxt;
      BUSY    <= (state_nxt != ST_IDLE);
      if (cmd_wr) begin
        op_r          <= PWDATA[`CMD_OP_MSB:`CMD_OP_LSB];
        target_sel_r  <= PWDATA[`CMD_TGT_BIT];             // RULE_01
        operand_reg_r <= PWDATA[`CMD_REG_MSB:`CMD_REG_LSB]; // RULE_01
      end
    end
  end

  // File registers; write-back only for target_sel 1
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (i = 0; i < 128; i = i + 1) begin
        file_r[i] <= 8'h00;
      end
    end else if (exec & has_result & target_sel_r) begin
      file_r[operand_reg_r] <= alu_result; // RULE_01
    end else if (fdat_wr) begin
      file_r[findex_r] <= PWDATA[7:0];
    end
  end

  // Accumulator and software index
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      acc_r    <= `ACC_RST;
      findex_r <= 7'h00;
    end else begin
      if (exec & has_result & ~target_sel_r) begin
        acc_r <= alu_result; // RULE_01
      end else if (acc_wr) begin
        acc_r <= PWDATA[7:0];
      end
      if (fidx_wr) begin
        findex_r <= PWDATA[6:0];
      end
    end
  end

  // Arithmetic flags; hardware update wins over a software write
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      rotate_out_bit_r   <= 1'b0;
      result_null_flag_r <= 1'b0;
      wdog_en_r          <= 1'b0;
    end else begin
      if (exec & upd_carry) begin
        rotate_out_bit_r <= alu_carry; // RULE_11
      end else if (stat_wr) begin
        rotate_out_bit_r <= PWDATA[`ST_CARRY_BIT];
      end
      if (exec & upd_zero) begin
        result_null_flag_r <= alu_zero; // RULE_02 RULE_03
      end else if (stat_wr) begin
        result_null_flag_r <= PWDATA[`ST_ZERO_BIT];
      end
      if (stat_wr) begin
        wdog_en_r <= PWDATA[`ST_WDEN_BIT];
      end
    end
  end

  // Program counter: step per operation, return reloads from stack
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      program_counter_r <= `PCNT_RST;
    end else if (do_return) begin
      program_counter_r <= stack_top; // RULE_09
    end else if (exec) begin
      program_counter_r <= program_counter_r + 13'h0001;
    end else if (pc_wr) begin
      program_counter_r <= PWDATA[12:0];
    end
  end

  // Power flags are active low; both read 1 after reset
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      power_down_flag_r <= 1'b1;
      timeout_flag_r    <= 1'b1;
    end else if (do_sleep) begin
      timeout_flag_r    <= 1'b1; // RULE_06
      power_down_flag_r <= 1'b0; // RULE_06
    end else if (wdog_wrap) begin
      timeout_flag_r    <= 1'b0;
    end
  end

  // Sleep entry wins over a same-cycle wake
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      sleeping_r <= 1'b0;
      SLEEP_MODE <= 1'b0;
    end else begin
      if (do_sleep) begin
        sleeping_r <= 1'b1; // RULE_08
        SLEEP_MODE <= 1'b1; // RULE_08
      end else if (wake_wr | wdog_wrap) begin
        sleeping_r <= 1'b0;
        SLEEP_MODE <= 1'b0;
      end
    end
  end

  // Watchdog keeps counting in sleep so it can wake the core
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      prescaler_r        <= `WDOG_RST;
      watchdog_counter_r <= `WDOG_RST;
    end else if (do_sleep) begin
      prescaler_r        <= 8'h00; // RULE_07
      watchdog_counter_r <= 8'h00; // RULE_07
    end else if (wdog_en_r) begin
      prescaler_r <= prescaler_r + 8'h01;
      if (prescaler_r == 8'hFF) begin
        watchdog_counter_r <= watchdog_counter_r + 8'h01;
      end
    end
  end

endmodule // fileop_core

// [verilog/fileop_regs.vh]
// Summary of operation
// [RULE_01] File operations take a 7-bit register address and send the result to the accumulator when target_sel is 0, else back to the register.
// [RULE_02] increment_file adds one to the register and updates only result_null_flag.
// [RULE_03] or_w_with_file ORs accumulator and register and updates only result_null_flag.
// [RULE_04] rotate_left_carry rotates the register left through rotate_out_bit and changes no other status bit.
// [RULE_05] rotate_right_carry rotates the register right through rotate_out_bit and changes no other status bit.
// [RULE_06] Sleep sets the active-low timeout_flag to 1, clears the active-low power_down_flag to 0 and touches no other status bit.
// [RULE_07] Sleep loads watchdog_counter with zero and clears its prescaler.
// [RULE_08] After sleep the core halts and runs no instruction until a wake condition.
// [RULE_09] Return pops the call stack into program_counter and leaves status unchanged.
// [RULE_10] Return takes two instruction cycles.
// [RULE_11] Rotations form a 9-bit ring of register and carry in both directions.
// [RULE_12] Increment, OR, rotate and sleep complete in one instruction cycle.
`ifndef FILEOP_REGS_VH
`define FILEOP_REGS_VH

// Register byte addresses
`define CMD_ADDR      8'h00
`define STATUS_ADDR   8'h04
`define ACC_ADDR      8'h08
`define PCNT_ADDR     8'h0C
`define STACK_ADDR    8'h10
`define FINDEX_ADDR   8'h14
`define FDATA_ADDR    8'h18
`define WDOG_ADDR     8'h1C
`define WAKE_ADDR     8'h20

// Command word fields
`define CMD_OP_LSB    0
`define CMD_OP_MSB    2
`define CMD_TGT_BIT   3
`define CMD_REG_LSB   4
`define CMD_REG_MSB   10

// Operation codes
`define OP_INC        3'h0
`define OP_IOR        3'h1
`define OP_ROTL       3'h2
`define OP_ROTR       3'h3
`define OP_SLEEP      3'h4
`define OP_RETURN     3'h5

// Status bit positions
`define ST_BUSY_BIT   0
`define ST_SLEEP_BIT  1
`define ST_CARRY_BIT  2
`define ST_ZERO_BIT   3
`define ST_PWDN_BIT   4
`define ST_TMO_BIT    5
`define ST_WDEN_BIT   6

// Reset values, stack depth and return cycle count
`define ACC_RST       8'h00
`define PCNT_RST      13'h0000
`define WDOG_RST      8'h00
`define STACK_DEPTH   8
`define RETURN_CYCLES 2

`endif

// [verilog/fileop_alu.v]
`timescale 1ns/1ps
`include "fileop_regs.vh"
// Combinational result and flag logic for the file operations
module fileop_alu (
  input  wire [2:0] op,
  input  wire [7:0] acc,
  input  wire [7:0] fval,
  input  wire       carry,
  output reg  [7:0] result,
  output reg        carry_out,
  output wire       zero_out,
  output reg        upd_zero,
  output reg        upd_carry,
  output reg        has_result
);

  // Zero test only meaningful where upd_zero is set
  assign zero_out = (result == 8'h00);

  // Operation select
  always @* begin
    result     = fval;
    carry_out  = carry;
    upd_zero   = 1'b0;
    upd_carry  = 1'b0;
    has_result = 1'b0;
    case (op)
      `OP_INC: begin
        result     = fval + 8'h01; // RULE_02
        upd_zero   = 1'b1;         // RULE_02
        has_result = 1'b1;
      end
      `OP_IOR: begin
        result     = acc | fval;   // RULE_03
        upd_zero   = 1'b1;         // RULE_03
        has_result = 1'b1;
      end
      `OP_ROTL: begin
        result     = {fval[6:0], carry}; // RULE_11
        carry_out  = fval[7];            // RULE_04
        upd_carry  = 1'b1;               // RULE_04
        has_result = 1'b1;
      end
      `OP_ROTR: begin
        result     = {carry, fval[7:1]}; // RULE_11
        carry_out  = fval[0];            // RULE_05
        upd_carry  = 1'b1;               // RULE_05
        has_result = 1'b1;
      end
      default: begin
        has_result = 1'b0;
      end
    endcase
  end

endmodule // fileop_alu

// [verilog/fileop_stack.v]
`timescale 1ns/1ps
`include "fileop_regs.vh"
// Return address stack held in flip-flops
module fileop_stack (
  input  wire        clk,
  input  wire        rst,
  input  wire        push,
  input  wire        pop,
  input  wire [12:0] push_val,
  output wire [12:0] top,
  output wire [3:0]  depth
);

  reg [12:0] slot_r [0:`STACK_DEPTH-1];
  reg [2:0]  ptr_r;
  reg [3:0]  cnt_r;
  integer    i;

  // Pointer wraps like a circular stack; overflow drops the oldest
  assign top   = slot_r[ptr_r - 3'd1];
  assign depth = cnt_r;

  // Push and pop never coincide; the core only pushes when idle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_r <= 3'd0;
      cnt_r <= 4'd0;
      for (i = 0; i < `STACK_DEPTH; i = i + 1) begin
        slot_r[i] <= 13'h0000;
      end
    end else if (push) begin
      slot_r[ptr_r] <= push_val;
      ptr_r         <= ptr_r + 3'd1;
      if (cnt_r != 4'd`STACK_DEPTH) begin
        cnt_r <= cnt_r + 4'd1;
      end
    end else if (pop) begin
      ptr_r <= ptr_r - 3'd1; // RULE_09
      if (cnt_r != 4'd0) begin
        cnt_r <= cnt_r - 4'd1;
      end
    end
  end

endmodule // fileop_stack

// [tb/fileop_core_monitor.sv]
`timescale 1ns/1ps
`include "fileop_regs.vh"
// Watches register port timing and execution flags of the core
module fileop_core_monitor (
  input wire        CLK,
  input wire        RST,
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [7:0]  PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire        PREADY,
  input wire        PSLVERR,
  input wire        SLEEP_MODE,
  input wire        BUSY
);
  reg  [2:0] op_r;
  wire       acc_cmd;

  // Command write that the core takes
  assign acc_cmd = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR &&
                   PADDR == `CMD_ADDR;

  // Op of the last taken command, so BUSY length can be judged
  always @(posedge CLK or posedge RST) begin
    if (RST)
      op_r <= 3'h0;
    else if (acc_cmd)
      op_r <= PWDATA[2:0];
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  AST_READY_SETUP: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no answer after setup");
  AST_READY_PULSE: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  AST_READY_CAUSE: assert property (PREADY |-> $past(PSEL && !PENABLE))
    else $error("ready without setup");
  AST_CMD_BUSY:
    assert property (acc_cmd |=> BUSY)
    else $error("busy late or missing");
  AST_BUSY_ONE:
    assert property ($rose(BUSY) && op_r != `OP_RETURN |=> !BUSY)
    else $error("single cycle op too long");
  AST_BUSY_TWO:
    assert property ($rose(BUSY) && op_r == `OP_RETURN
      |=> BUSY ##1 !BUSY) else $error("return not two cycles");
  AST_SLEEP_CAUSE:
    assert property ($rose(SLEEP_MODE) |-> op_r == `OP_SLEEP)
    else $error("sleep without sleep op");
  AST_SLEEP_IDLE: assert property (SLEEP_MODE |-> !BUSY)
    else $error("executing while asleep");
  AST_SLEEP_REFUSE:
    assert property (PREADY && PWRITE && PADDR == `CMD_ADDR && SLEEP_MODE
      && $past(SLEEP_MODE) |-> PSLVERR) else $error("command taken asleep");
  AST_UNMAPPED: assert property (PREADY && !PWRITE && PADDR > `WAKE_ADDR
    |-> PSLVERR && PRDATA == 32'h0000_0000) else $error("unmapped read");
endmodule // fileop_core_monitor

bind fileop_core fileop_core_monitor mon (.CLK(CLK), .RST(RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .SLEEP_MODE(SLEEP_MODE), .BUSY(BUSY));

// [tb/test_file_register_op_subset.sv]
`timescale 1ns/1ps
`include "fileop_regs.vh"
`define CHK(a, b) begin checks = checks + 1; if ((a) !== (b)) begin \
  fail_count = fail_count + 1; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end

module test_file_register_op_subset;
  reg         clk;
  reg         rst;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg         e;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata;
  reg  [31:0] q;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire        sleep_mode;
  wire        busy;
  integer     fail_count;
  integer     checks;
  integer     n;

  fileop_core dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SLEEP_MODE(sleep_mode),
    .BUSY(busy));

  // 20 MHz core clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task results;
    begin
      if (fail_count == 0 && checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  task timeout;
    begin
      fail_count = fail_count + 1;
      $display("unexpected at %0t: wait ran out", $time);
      results;
    end
  endtask

  // One transfer; answer is taken only at the edge that sees pready
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge clk);
        n = n + 1;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
        timeout;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task wr(input [7:0] a, input [31:0] d);
    begin
      apb(1'b1, a, d);
      `CHK(e, 1'b0)
    end
  endtask

  task rd(input [7:0] a, input [7:0] x);
    begin
      apb(1'b0, a, 32'h0000_0000);
      `CHK(q[7:0], x)
    end
  endtask

  task setf(input [6:0] i, input [7:0] v);
    begin
      wr(`FINDEX_ADDR, {25'h0, i});
      wr(`FDATA_ADDR, {24'h0, v});
    end
  endtask

  task rdf(input [6:0] i, input [7:0] x);
    begin
      wr(`FINDEX_ADDR, {25'h0, i});
      rd(`FDATA_ADDR, x);
    end
  endtask

  task rdpcnt(input [12:0] x);
    begin
      apb(1'b0, `PCNT_ADDR, 32'h0000_0000);
      `CHK(q[12:0], x)
    end
  endtask

  // Issue a command and count the cycles BUSY stays up
  task exec(input [2:0] op, input t, input [6:0] r, input integer cyc);
    begin
      wr(`CMD_ADDR, {21'h0, r, t, op});
      n = 0;
      while (busy !== 1'b1 && n < 10) begin
        @(posedge clk);
        n = n + 1;
      end
      if (busy !== 1'b1)
        timeout;
      n = 0;
      while (busy === 1'b1 && n < 10) begin
        @(posedge clk);
        n = n + 1;
      end
      `CHK(n, cyc)
    end
  endtask

  task waitsl(input v);
    begin
      n = 0;
      while (sleep_mode !== v && n < 10) begin
        @(posedge clk);
        n = n + 1;
      end
      if (sleep_mode !== v)
        timeout;
    end
  endtask

  // Main sequence; status bits: 2 carry, 3 zero, 4 power down,
  // 5 timeout, 6 watchdog enable
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    fail_count = 0;
    checks = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(`STATUS_ADDR, 8'h30);
    rd(`ACC_ADDR, 8'h00);
    wr(`STATUS_ADDR, 32'h0000_0004);
    setf(7'h7f, 8'hff);
    exec(`OP_INC, 1'b1, 7'h7f, 1);
    rdf(7'h7f, 8'h00);
    rd(`STATUS_ADDR, 8'h3c);
    setf(7'h00, 8'h41);
    exec(`OP_INC, 1'b0, 7'h00, 1);
    rd(`ACC_ADDR, 8'h42);
    rdf(7'h00, 8'h41);
    rd(`STATUS_ADDR, 8'h34);
    setf(7'h05, 8'h81);
    exec(`OP_IOR, 1'b0, 7'h05, 1);
    rd(`ACC_ADDR, 8'hc3);
    wr(`ACC_ADDR, 32'h0000_0000);
    setf(7'h06, 8'h00);
    exec(`OP_IOR, 1'b1, 7'h06, 1);
    rd(`STATUS_ADDR, 8'h3c);
    wr(`STATUS_ADDR, 32'h0000_0008);
    exec(`OP_ROTL, 1'b1, 7'h05, 1);
    rdf(7'h05, 8'h02);
    rd(`STATUS_ADDR, 8'h3c);
    exec(`OP_ROTR, 1'b0, 7'h05, 1);
    rd(`ACC_ADDR, 8'h81);
    rd(`STATUS_ADDR, 8'h38);
    rdpcnt(13'h0006);
    wr(`STACK_ADDR, 32'h0000_0abc);
    apb(1'b0, `STACK_ADDR, 32'h0000_0000);
    `CHK(q, 32'h0001_0abc)
    exec(`OP_RETURN, 1'b0, 7'h00, 2);
    rdpcnt(13'h0abc);
    rd(`STATUS_ADDR, 8'h38);
    // Let the watchdog count past one counter step before sleeping
    wr(`STATUS_ADDR, 32'h0000_0048);
    repeat (300) @(posedge clk);
    wr(`CMD_ADDR, {29'h0, `OP_SLEEP});
    waitsl(1'b1);
    apb(1'b0, `WDOG_ADDR, 32'h0000_0000);
    `CHK(q[7:0], 8'h00)
    `CHK(q[15:8] < 8'h10, 1'b1)
    rd(`STATUS_ADDR, 8'h6a);
    apb(1'b1, `CMD_ADDR, {29'h0, `OP_INC});
    `CHK(e, 1'b1)
    repeat (5) @(posedge clk);
    `CHK(busy, 1'b0)
    rdpcnt(13'h0abd);
    wr(`WAKE_ADDR, 32'h0000_0001);
    waitsl(1'b0);
    wr(`STATUS_ADDR, 32'h0000_0008);
    apb(1'b0, 8'h40, 32'h0000_0000);
    `CHK(e, 1'b1)
    `CHK(q, 32'h0000_0000)
    results;
  end
endmodule // test_file_register_op_subset
